// File: core/asc_defs.svh
// constants of the converter sequence controller: offsets, fields, resets, timing
// assumes inclusion by the package and the design modules of this block
//
// Operation
// (R1) converter clock is peripheral clock over prescale plus one, then halved
// (R2) prescale of zero leaves only the divide-by-two stage
// (R3) prescale field resets to one, total divisor four
// (R4) software keeps converter clock between 500 kHz and 2 MHz
// (R5) length bit set gives eight conversions, clear gives four
// (R6) continuous bit set repeats sequences, clear runs one
// (R7) single-channel mode converts the selected input every time
// (R8) multichannel mode converts inputs in ascending order from group start
// (R9) multichannel mode ignores low select bits, upper bits pick group
// (R10) sequence position picks result register; code 11 picks references and test
// (R11) single mode sets sequence-complete flag at sequence end
// (R12) continuous mode sets sequence-complete flag after first sequence
// (R13) sequence control write clears it; fast clear also on result read
// (R14) three-bit conversion counter readable, points at current conversion
// (R15) each conversion-complete flag sets when its conversion finishes
// (R16) normal clearing needs status one read then matching result read
// (R17) fast clearing clears flag on result read alone
// (R18) status registers read anytime, written only in special mode
// (R19) test registers read zero and ignore writes outside special mode
// (R20) approximation field reads current value, write loads it
// (R21) soft reset returns all to reset state except power-up enable
// (R22) four-bit test field routes one of sixteen sources to test output
// (R23) sequence control write starts new sequence, aborting and clearing flags
// (R24) conversion is 2 sample, 4 transfer, final sample, 10 resolution clocks
// (R25) power-up enable gates converter clock; registers stay accessible
// (R26) software avoids prescale codes with upper bits set
// (R27) continuous mode restarts at position zero, counter wraps
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ==============================
// register byte offsets
`define ASC_OFF_CTRL     8'h00
`define ASC_OFF_PRESCALE 8'h04
`define ASC_OFF_SEQ      8'h08
`define ASC_OFF_STAT1    8'h0C
`define ASC_OFF_STAT2    8'h10
`define ASC_OFF_TEST1    8'h14
`define ASC_OFF_TEST2    8'h18
`define ASC_OFF_RES0     8'h20

// ==============================
// field positions
`define ASC_CTRL_PWR     7
`define ASC_CTRL_FAST    6
`define ASC_SEQ_LEN      6
`define ASC_SEQ_SCAN     5
`define ASC_SEQ_MULTICHANNEL_SELECT     4
`define ASC_STAT1_SCF    7
`define ASC_TEST2_RST    6
`define ASC_TEST2_TOUT   5

// ==============================
// reset values
`define ASC_PRESCALE_RST 8'h01
`define ASC_CTRL_RST     8'h00
`define ASC_SEQ_RST      8'h00

// ==============================
// conversion phase lengths in converter clocks, then bus response codes
`define ASC_T_SAMPLE     5'h02
`define ASC_T_XFER       5'h04
`define ASC_T_RESOLVE    5'h0A
`define ASC_SLVERR       2'h2
`define ASC_OKAY         2'h0

`endif

// File: core/asc_pkg.sv
// types of the converter sequence controller
// assumes asc_defs.svh is on the include path
package asc_pkg;
  `include "asc_defs.svh"

  typedef enum logic [2:0] {
    ASC_IDLE     = 3'b000,
    ASC_SAMPLE   = 3'b001,
    ASC_XFER     = 3'b010,
    ASC_FINAL    = 3'b011,
    ASC_RESOLVE  = 3'b100
  } asc_state_t;

  typedef struct packed {
    logic       len8;
    logic       scan;
    logic       multichannel_select;
    logic [3:0] chan;
  } asc_seq_cfg_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [2:0] slot;
    logic       last;
  } asc_step_t;
endpackage : asc_pkg

// File: core/asc_clkdiv.sv
// prescaler and divide-by-two stage, giving a one-cycle converter clock tick
// assumes prescale value is steady while the converter runs
`timescale 1ns/1ps
module asc_clkdiv
  import asc_pkg::*;
#(
  parameter int PW = 5
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // control
  input  wire logic          run,
  input  wire logic [PW-1:0] prescale,
  // tick at each converter clock rising edge
  output logic               tick
);
  logic [PW-1:0] cnt_r;
  logic          half_r;

  // prescale plus one, then halved for symmetry; zero prescale halves only
  // stopped clock rests high, so the first rise after a restart is a full period away
  always_ff @(posedge clk_sys) begin // see (R1) (R2)
    if (!rst_b || !run) begin
      cnt_r  <= '0;
      half_r <= 1'b1;
    end else if (cnt_r >= prescale) begin
      cnt_r  <= '0;
      half_r <= ~half_r;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  // high in the cycle whose closing edge raises the converter clock
  assign tick = rst_b && run && !half_r && (cnt_r >= prescale);
endmodule : asc_clkdiv

// File: core/asc_top.sv
// converter sequence controller with an AXI4-Lite register slave
// assumes the analogue comparator answers on cmp_hi during resolution
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_top
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // chip mode
  input  wire logic        special_mode,
  // AXI4-Lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // analogue front end
  input  wire logic        cmp_hi,
  input  wire logic [15:0] test_src,
  output logic [3:0]       mux_sel_r,
  output logic             sample_on_r,
  output logic             test_out_r
);
  // ==============================
  // registers
  logic [7:0]   ctrl_r;
  logic [7:0]   presc_r;
  asc_seq_cfg_t seq_r;
  logic         scf_r;
  logic [7:0]   ccf_r;
  logic [7:0]   armed_r;
  logic [2:0]   cnt_r;
  logic [9:0]   sar_r;
  logic [4:0]   tst_r;
  logic         tout_sel_r;
  logic [7:0]   res_r [8];
  asc_state_t   st_r;
  logic [4:0]   ph_r;
  logic [3:0]   bit_r;
  logic         first_r;

  // ==============================
  // bus handshake state
  logic        aw_ok_r, w_ok_r;
  logic [7:0]  aw_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wr_go, rd_go, soft_rst;
  logic        wr_seq, wr_test, rd_stat1;
  logic [7:0]  rd_res;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [7:0] res_hit(input logic [7:0] a);
    res_hit = '0;
    if (a[7:5] == 3'b001 && a[1:0] == 2'b00) begin
      res_hit[a[4:2]] = 1'b1;
    end
  endfunction : res_hit

  assign wr_go    = aw_ok_r && w_ok_r && !s_bvalid;
  assign rd_go    = s_arvalid && s_arready;
  assign wr_seq   = wr_go && hit(aw_r, `ASC_OFF_SEQ) && ws_r[0];
  assign wr_test  = wr_go && special_mode && ws_r[0]; // see (R19)
  assign soft_rst = wr_test && hit(aw_r, `ASC_OFF_TEST2) && wd_r[`ASC_TEST2_RST]; // see (R21)
  assign rd_stat1 = rd_go && hit(s_araddr, `ASC_OFF_STAT1);
  assign rd_res   = rd_go ? res_hit(s_araddr) : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_ok_r   <= 1'b0;
      w_ok_r    <= 1'b0;
      aw_r      <= 8'h00;
      wd_r      <= 32'h00000000;
      ws_r      <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `ASC_OKAY;
    end else begin
      s_awready <= !aw_ok_r && !s_awready && !s_bvalid;
      s_wready  <= !w_ok_r && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_ok_r <= 1'b1;
        aw_r    <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_ok_r <= 1'b1;
        wd_r   <= s_wdata;
        ws_r   <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_r  <= 1'b0;
        w_ok_r   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (aw_r > `ASC_OFF_RES0 + 8'h1C) ? `ASC_SLVERR : `ASC_OKAY;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ==============================
  // read channel, one cycle latency
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h00000000;
      s_rresp   <= `ASC_OKAY;
    end else begin
      s_arready <= !s_rvalid && !s_arready;
      if (rd_go) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rresp   <= `ASC_OKAY;
        s_rdata   <= 32'h00000000;
        case (s_araddr)
          `ASC_OFF_CTRL:     s_rdata[7:0] <= ctrl_r;
          `ASC_OFF_PRESCALE: s_rdata[7:0] <= presc_r;
          `ASC_OFF_SEQ:      s_rdata[6:0] <= seq_r;
          `ASC_OFF_STAT1:    s_rdata[7:0] <= {scf_r, 4'h0, cnt_r}; // see (R14) (R18)
          `ASC_OFF_STAT2:    s_rdata[7:0] <= ccf_r;
          `ASC_OFF_TEST1:    s_rdata[9:0] <= special_mode ? sar_r : 10'h000; // see (R19) (R20)
          `ASC_OFF_TEST2:    s_rdata[7:0] <= special_mode ? {2'h0, tout_sel_r, tst_r} : 8'h00;
          default: begin
            if (|res_hit(s_araddr)) begin
              s_rdata[7:0] <= res_r[s_araddr[4:2]];
            end else begin
              s_rresp <= `ASC_SLVERR;
            end
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ==============================
  // control registers; power-up survives soft reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r  <= `ASC_CTRL_RST;
      presc_r <= `ASC_PRESCALE_RST; // see (R3)
      seq_r   <= asc_seq_cfg_t'(7'(`ASC_SEQ_RST));
    end else if (soft_rst) begin
      ctrl_r  <= `ASC_CTRL_RST | (ctrl_r & (8'h01 << `ASC_CTRL_PWR)); // see (R21)
      presc_r <= `ASC_PRESCALE_RST;
      seq_r   <= asc_seq_cfg_t'(7'(`ASC_SEQ_RST));
    end else if (wr_go && ws_r[0]) begin
      if (hit(aw_r, `ASC_OFF_CTRL)) ctrl_r <= wd_r[7:0];
      if (hit(aw_r, `ASC_OFF_PRESCALE)) presc_r <= wd_r[7:0];
      if (hit(aw_r, `ASC_OFF_SEQ)) seq_r <= wd_r[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst) begin
      tst_r      <= 5'h00;
      tout_sel_r <= 1'b0;
      test_out_r <= 1'b0;
    end else begin
      if (wr_test && hit(aw_r, `ASC_OFF_TEST2)) begin
        tst_r      <= wd_r[4:0];
        tout_sel_r <= wd_r[`ASC_TEST2_TOUT];
      end
      test_out_r <= tout_sel_r & test_src[tst_r[3:0]]; // see (R22)
    end
  end

  // ==============================
  // sequencer
  logic      tick, pwr, fast, abort, ph_end;
  logic [4:0] final_len;
  asc_step_t step;
  assign pwr   = ctrl_r[`ASC_CTRL_PWR];
  assign fast  = ctrl_r[`ASC_CTRL_FAST];
  assign abort = wr_seq || soft_rst || !pwr;
  assign final_len = 5'h02 << presc_r[6:5];

  asc_clkdiv #(.PW(5)) u_div (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .run      (pwr && !soft_rst && !wr_seq), // see (R25) (R24)
    .prescale (presc_r[4:0]),
    .tick     (tick)
  );

  always_comb begin
    step.slot = cnt_r;
    step.last = seq_r.len8 ? (cnt_r == 3'h7) : (cnt_r == 3'h3); // see (R5)
    if (!seq_r.multichannel_select) begin
      step.chan = seq_r.chan[2:0]; // see (R7)
    end else if (seq_r.len8) begin
      step.chan = cnt_r; // see (R8) (R9)
    end else begin
      step.chan = {seq_r.chan[2], cnt_r[1:0]};
    end
  end

  always_comb begin
    case (st_r)
      ASC_SAMPLE:  ph_end = (ph_r == `ASC_T_SAMPLE - 5'h01);
      ASC_XFER:    ph_end = (ph_r == `ASC_T_XFER - 5'h01);
      ASC_FINAL:   ph_end = (ph_r == final_len - 5'h01);
      ASC_RESOLVE: ph_end = (ph_r == `ASC_T_RESOLVE - 5'h01);
      default:     ph_end = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin // see (R24) (R27)
    if (!rst_b || abort) begin
      st_r    <= ASC_IDLE;
      ph_r    <= 5'h00;
      cnt_r   <= 3'h0;
      first_r <= 1'b1;
      bit_r   <= 4'h9;
    end else if (st_r == ASC_IDLE) begin
      if (seq_r != `ASC_SEQ_RST || first_r == 1'b0) st_r <= ASC_IDLE;
    end else if (tick) begin
      ph_r <= ph_end ? 5'h00 : ph_r + 5'h01;
      if (st_r == ASC_RESOLVE && bit_r != 4'h0) bit_r <= bit_r - 4'h1;
      if (ph_end) begin
        case (st_r)
          ASC_SAMPLE: st_r <= ASC_XFER;
          ASC_XFER:   st_r <= ASC_FINAL;
          ASC_FINAL:  st_r <= ASC_RESOLVE;
          ASC_RESOLVE: begin
            bit_r <= 4'h9;
            cnt_r <= cnt_r + 3'h1;
            if (step.last) begin
              cnt_r   <= 3'h0;
              first_r <= 1'b0;
              st_r    <= seq_r.scan ? ASC_SAMPLE : ASC_IDLE; // see (R6)
            end else begin
              st_r <= ASC_SAMPLE;
            end
          end
          default: st_r <= ASC_IDLE;
        endcase
      end
    end
    if (rst_b && wr_seq && pwr && !soft_rst) begin
      st_r <= ASC_SAMPLE; // see (R23)
    end
  end

  // successive approximation: trial bit kept when comparator says high
  logic conv_done;
  assign conv_done = tick && ph_end && st_r == ASC_RESOLVE;

  always_ff @(posedge clk_sys) begin // see (R20)
    if (!rst_b || soft_rst) begin
      sar_r <= 10'h000;
    end else if (wr_test && hit(aw_r, `ASC_OFF_TEST1)) begin
      sar_r <= {wd_r[9:2], 2'b00};
    end else if (st_r == ASC_FINAL && tick && ph_end) begin
      sar_r <= 10'h200;
    end else if (st_r == ASC_RESOLVE && tick && bit_r >= 4'h2) begin
      sar_r[bit_r] <= cmp_hi;
      if (bit_r != 4'h2) sar_r[bit_r - 4'h1] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mux_sel_r   <= 4'h0;
      sample_on_r <= 1'b0;
    end else begin
      mux_sel_r   <= {seq_r.chan[3], step.chan}; // see (R10)
      sample_on_r <= (st_r == ASC_SAMPLE) || (st_r == ASC_FINAL);
    end
  end

  // ==============================
  // result storage and flags
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_res
      always_ff @(posedge clk_sys) begin
        if (!rst_b || soft_rst) begin
          res_r[g]   <= 8'h00;
          ccf_r[g]   <= 1'b0;
          armed_r[g] <= 1'b0;
        end else if (conv_done && step.slot == 3'(g)) begin
          res_r[g]   <= sar_r[9:2]; // see (R10)
          ccf_r[g]   <= 1'b1; // see (R15)
          armed_r[g] <= 1'b0;
        end else if (wr_seq) begin
          ccf_r[g]   <= 1'b0; // see (R23)
          armed_r[g] <= 1'b0;
        end else if (wr_test && hit(aw_r, `ASC_OFF_STAT2)) begin
          ccf_r[g]   <= wd_r[g]; // see (R18)
        end else begin
          if (rd_stat1 && ccf_r[g]) armed_r[g] <= 1'b1;
          if (rd_res[g] && (fast || armed_r[g])) begin // see (R16) (R17)
            ccf_r[g]   <= 1'b0;
            armed_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst) begin
      scf_r <= 1'b0;
    end else if (conv_done && step.last && first_r) begin
      scf_r <= 1'b1; // see (R11) (R12)
    end else if (wr_seq || (fast && |rd_res)) begin
      scf_r <= 1'b0; // see (R13)
    end else if (wr_test && hit(aw_r, `ASC_OFF_STAT1)) begin
      scf_r <= wd_r[`ASC_STAT1_SCF];
    end
  end
endmodule : asc_top

// File: verification/asc_top_chk.sv
// checker of the converter sequence controller top ports
// assumes bind from the bench top file
`timescale 1ns/1ps
module asc_top_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        special_mode,
  // register bus
  input wire logic [7:0]  s_awaddr,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [7:0]  s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // front end
  input wire logic        sample_on_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==============================
  // bus handshakes
  bvalid_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read response changed early");
  read_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  one_read_a: assert property (s_rvalid |-> !s_arready)
    else $error("second read taken");
  bad_read_a: assert property (s_arvalid && s_arready && s_araddr > 8'h3C
    |=> s_rresp == 2'h2 && s_rdata == 32'h0) else $error("unmapped read not refused");
  bad_write_a: assert property (s_awvalid && s_awready && s_awaddr > 8'h3C
    |-> ##[1:8] (s_bvalid && s_bresp == 2'h2)) else $error("unmapped write not refused");
  test_zero_a: assert property (s_arvalid && s_arready && !special_mode &&
    (s_araddr == 8'h14 || s_araddr == 8'h18) |=> s_rdata == 32'h0) else $error("test read");
  // ==============================
  // conversion timing and reset
  sample_min_a: assert property ($rose(sample_on_r) |-> sample_on_r[*4])
    else $error("sample phase too short");
  reset_idle_a: assert property ($rose(rst_b) |-> !s_bvalid && !s_rvalid && !sample_on_r)
    else $error("outputs busy after reset");
endmodule : asc_top_chk

// File: verification/asc_afe_model.sv
// analogue front end model: comparator and factory test sources
// assumes the controller drives the mux select
`timescale 1ns/1ps
module asc_afe_model #(
  parameter logic [15:0] SRC = 16'hC35A
) (
  // mux select from the controller
  input wire logic [3:0] mux_sel_r,
  // comparator answer and test sources
  output logic           cmp_hi,
  output logic [15:0]    test_src
);
  // even inputs sit above every trial level, odd ones below
  assign cmp_hi   = ~mux_sel_r[0];
  assign test_src = SRC;
endmodule : asc_afe_model

// File: verification/test_adc_sequence_controller.sv
// self-checking bench of the converter sequence controller
// assumes asc_pkg compiled first, AXI4-Lite master tasks below
`timescale 1ns/1ps
module test_adc_sequence_controller;
  import asc_pkg::*;
  localparam logic [15:0] TSRC = 16'hC35A;
  logic        clk_sys, rst_b, special_mode, cmp_hi, sample_on_r, test_out_r;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr, lf;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0]  s_wstrb, mux_sel_r;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [15:0] test_src;
  int          n_mismatch, n_tests, l0, l3, cnt;

  asc_top asc_top_inst (.clk_sys, .rst_b, .special_mode, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .cmp_hi, .test_src,
    .mux_sel_r, .sample_on_r, .test_out_r);
  asc_afe_model #(.SRC(TSRC)) asc_afe_model_inst (.mux_sel_r, .cmp_hi, .test_src);

  // ==============================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [7:0] exp_res(input logic [2:0] ch);
    return ch[0] ? 8'h00 : 8'hFF;
  endfunction : exp_res
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
    @(posedge clk_sys);
    s_awaddr  <= a;
    s_wdata   <= v;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    rr = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rr);
    @(posedge clk_sys);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    q = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask : rc
  task automatic wait_scf;
    int n;
    n = 0;
    do begin
      rd(8'h0C, d, r);
      n++;
    end while (!d[7] && n < 2000);
    chk(d[7], 1'b1);
  endtask : wait_scf
  task automatic pulse(output int len);
    int n;
    n = 0;
    len = 0;
    while (!sample_on_r && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    while (sample_on_r && len < 2000) begin
      @(posedge clk_sys);
      len++;
    end
  endtask : pulse

  // ==============================
  // clock, watchdog, main sequence
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #3000000;
    n_mismatch++;
    summarize;
  end
  initial begin
    {rst_b, special_mode, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 7'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    n_mismatch = 0;
    n_tests = 0;
    lf = 8'h4A;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc(8'h04, 32'h01);
    rc(8'h00, 32'h00);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    wr(8'h40, 32'h0, r);
    chk(r, 2'h2);
    wr(8'h14, 32'h3FC, r);
    rc(8'h14, 32'h0);
    special_mode <= 1'b1;
    lf = lfsr(lf);
    wr(8'h14, {22'h0, lf, 2'b00}, r);
    rc(8'h14, {22'h0, lf, 2'b00});
    for (int f = 0; f < 16; f++) begin
      wr(8'h18, 32'h20 | f, r);
      repeat (2) @(posedge clk_sys);
      chk(test_out_r, TSRC[f]);
    end
    wr(8'h00, 32'hC0, r);
    wr(8'h04, 32'h05, r);
    wr(8'h18, 32'h40, r);
    repeat (2) @(posedge clk_sys);
    rc(8'h04, 32'h01);
    rc(8'h00, 32'h80);
    special_mode <= 1'b0;
    wr(8'h00, 32'h00, r);
    wr(8'h08, 32'h10, r);
    repeat (300) @(posedge clk_sys);
    rc(8'h10, 32'h00);
    wr(8'h10, 32'hFF, r);
    rc(8'h10, 32'h00);
    wr(8'h00, 32'h80, r);
    // converter clock kept between 500 kHz and 2 MHz, upper prescale bits clear
    wr(8'h04, 32'h04, r);
    // low select bits set on purpose: ignored in multichannel mode
    for (int m = 0; m < 2; m++) begin
      wr(8'h08, m ? 32'h56 : 32'h13, r);
      wait_scf;
      rc(8'h10, m ? 32'hFF : 32'h0F);
      for (int i = 0; i < 4 * (m + 1); i++) rc(8'h20 + 8'(4 * i), exp_res(3'(i)));
      rc(8'h10, 32'h00);
    end
    wr(8'h00, 32'hC0, r);
    lf = lfsr(lf);
    wr(8'h08, {29'h0, lf[2:0]}, r);
    rc(8'h0C, 32'h00);
    wait_scf;
    rc(8'h20, exp_res(lf[2:0]));
    rc(8'h10, 32'h0E);
    rd(8'h0C, d, r);
    chk(d[7], 1'b0);
    for (int i = 1; i < 4; i++) rc(8'h20 + 8'(4 * i), exp_res(lf[2:0]));
    wr(8'h08, 32'h30, r);
    wait_scf;
    cnt = 0;
    repeat (400) begin
      @(posedge clk_sys);
      cnt += sample_on_r;
    end
    chk(cnt != 0, 1'b1);
    wr(8'h08, 32'h10, r);
    rc(8'h10, 32'h00);
    rd(8'h0C, d, r);
    chk(d[7], 1'b0);
    wait_scf;
    // sample phase is two converter clocks of twice prescale plus one each
    wr(8'h08, 32'h10, r);
    pulse(l0);
    wait_scf;
    wr(8'h04, 32'h07, r);
    wr(8'h08, 32'h10, r);
    pulse(l3);
    wait_scf;
    chk(l0, 2 * 2 * (4 + 1));
    chk(l3, 2 * 2 * (7 + 1));
    summarize;
  end
endmodule : test_adc_sequence_controller

bind asc_top asc_top_chk asc_top_chk_inst (.clk_sys, .rst_b, .special_mode, .s_awaddr,
  .s_awvalid, .s_awready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
  .s_rdata, .s_rresp, .s_rvalid, .s_rready, .sample_on_r);
